/* verilog/rst_seq_defines.vh */
`ifndef RST_SEQ_DEFINES_VH
`define RST_SEQ_DEFINES_VH
// APB register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PSW 12'h008
`define OFS_CLK 12'h00c
`define OFS_MEM 12'h010
`define OFS_T16 12'h014
`define OFS_T16CC 12'h018
`define OFS_T8 12'h01c
`define OFS_PORTDIR 12'h020
`define OFS_PORTLAT 12'h024
`define OFS_PULLUP 12'h028
`define OFS_VECTOR 12'h02c
// Reset values
`define RV_PSW 8'h02
`define RV_PCC 8'h04
`define RV_OSCILLATOR_MODE_SELECT 8'h00
`define RV_OSCILLATION_WAIT_SELECT 8'h04
`define RV_MM 8'h10
`define RV_IXS 8'h0a
`define RV_IMS 8'hcf
`define RV_ZERO 8'h00
`define RV_TIMER16_CAPCMP_CONTROL 8'h04
`define RV_DIR 8'hff
// Reset vector addresses
`define VEC_LO 16'h0000
`define VEC_HI 16'h0001
// Stabilization: 2^17 main-clock periods
`define OSC_WAIT_LOG2 17
// Control register bit positions
`define CB_STOP 0
`define CB_IE 1
`define CB_ISP 2
`define CB_MASK 3
`define CB_LEVEL 4
`define CB_TMASK 5
// Release outcome codes
`define OUT_NONE 2'h0
`define OUT_NEXT 2'h1
`define OUT_IRQ 2'h2
`define OUT_RESET 2'h3
`endif

/* verilog/reset_sync.v */
`timescale 1ns/1ps
// Pin reset synchroniser: asserts at once, releases after two edges
module reset_sync (
   // Clock and raw sources
   input wire pclk,
   input wire presetn,
   input wire raw_n,
   // Synchronised result, active low
   output wire sync_n
);
   reg stage1; // Only read by stage2
   reg stage2;

   // Asynchronous assert, clean synchronous release
   always @(posedge pclk or negedge presetn or negedge raw_n) begin
      if (!presetn || !raw_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         stage2 <= stage1;
      end
   end
   assign sync_n = stage2;
endmodule

/* verilog/osc_wait.v */
`timescale 1ns/1ps
`include "rst_seq_defines.vh"
// Counter of main-clock periods for oscillation stabilization
module osc_wait #(
   parameter WAIT_LOG2 = `OSC_WAIT_LOG2
) (
   // Clock, enable and reset
   input wire pclk,
   input wire presetn,
   input wire ce,
   // Clear restarts the count, run lets it advance
   input wire clear,
   input wire run,
   // High once the full interval has passed
   output reg done
);
   reg [WAIT_LOG2-1:0] count;

   // Count up to 2^WAIT_LOG2 - 1, then flag done
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {WAIT_LOG2{1'b0}};
         done <= 1'b0;
      end else if (ce) begin
         if (clear) begin
            count <= {WAIT_LOG2{1'b0}};
            done <= 1'b0;
         end else if (run && !done) begin
            count <= count + 1'b1;
            done <= &count;
         end
      end
   end
endmodule

/* verilog/reset_sequencer.v */
`timescale 1ns/1ps
`include "rst_seq_defines.vh"
// How it works
// - Reset in STOP: reset at once, then wait
// - Interrupt release: level, enable, in-service flag decide vectoring
// - Unmasked test input releases; masked holds STOP
// - Interrupt release waits stabilization first
// - Pin and watchdog resets act identically
// - Start fetch at vector in lowest addresses
// - Either source enters reset, defaults loaded
// - Pins high impedance during reset and wait
// - Wait 2^17 clocks after reset release
// - Watchdog reset self-releases, same wait
// - Main oscillator stopped during reset
// - Reset from STOP keeps STOP bit only while reset is held
// - Program counter undefined meanwhile
// - Standby reset keeps memory, reloads register defaults
// - Status word 02h, stack undefined
// - Port latches cleared, some undefined
// - Directions FFh, pull-ups 00h
// - Clock control 04h, oscillator mode 00h
// - Wait select register 04h
// - Expansion mode 10h, expansion RAM 0Ah
// - Memory size variant value, default CFh
// - 16-bit timer defaults, control 04h
// - 8-bit timer defaults, compares undefined
module reset_sequencer #(
   parameter WAIT_LOG2 = `OSC_WAIT_LOG2,
   parameter [7:0] MEM_SIZE_RESET = `RV_IMS
) (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Clock enable
   input wire ce,
   // Reset sources and release events
   input wire ext_reset_n,
   input wire watchdog_overflow,
   input wire irq_request,
   input wire test_request,
   // Core side
   output reg core_reset,
   output reg [15:0] vector_fetch_addr,
   output reg fetch_vector,
   output reg release_next,
   output reg release_irq,
   output wire pins_hiz,
   output wire main_osc_run,
   output wire stop_mode
);
   // One-hot states
   localparam [4:0] ST_RUN = 5'h01;
   localparam [4:0] ST_STOP = 5'h02;
   localparam [4:0] ST_WAKE = 5'h04;
   localparam [4:0] ST_RESET = 5'h08;
   localparam [4:0] ST_RWAIT = 5'h10;

   reg [4:0] state;
   reg [4:0] next_state;
   reg [1:0] outcome; // What follows the STOP wake wait
   reg [1:0] next_outcome;

   // Software-visible registers
   reg [7:0] ctrl; // STOP request, enables, flags
   reg [7:0] processor_status_word;
   reg [7:0] cpu_clock_control;
   reg [7:0] oscillator_mode_select;
   reg [7:0] oscillation_wait_select;
   reg [7:0] mm;
   reg [7:0] expansion_ram_size;
   reg [7:0] internal_memory_size;
   reg [7:0] t16_count, t16_clk, t16_mode, t16_out, t16_cc;
   reg [15:0] t16_capcmp_a, t16_capcmp_b; // No reset value
   reg [7:0] t8a_count, t8b_count, t8_clk, t8_mode, t8_out;
   reg [7:0] t8a_cmp, t8b_cmp; // No reset value
   reg [71:0] port_dir; // Nine ports' direction registers
   reg [55:0] port_latch; // Cleared ports only
   reg [7:0] pullup_high, pullup_low;
   reg [15:0] vector_word; // Reset vector contents from memory

   // Synchronised inputs
   wire pin_rst_n;
   reg [1:0] wd_s, irq_s, tst_s;
   wire wd_evt = wd_s[1];
   wire irq_evt = irq_s[1];
   wire tst_evt = tst_s[1];
   wire wait_done;
   wire internal_rst = !pin_rst_n || wd_evt;

   reset_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .raw_n(ext_reset_n),
      .sync_n(pin_rst_n)
   );

   osc_wait #(.WAIT_LOG2(WAIT_LOG2)) u_wait (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(state == ST_RESET || state == ST_STOP),
      .run(state == ST_WAKE || state == ST_RWAIT),
      .done(wait_done)
   );

   // Two-flop synchronisers for asynchronous event inputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_s <= 2'b00;
         irq_s <= 2'b00;
         tst_s <= 2'b00;
      end else if (ce) begin
         wd_s <= {wd_s[0], watchdog_overflow};
         irq_s <= {irq_s[0], irq_request};
         tst_s <= {tst_s[0], test_request};
      end
   end

   // Decide the STOP release result from the flags
   function [1:0] irq_outcome;
      input level, ie, in_service_level_flag;
      begin
         if (!level)
            irq_outcome = ie ? `OUT_IRQ : `OUT_NEXT;
         else
            irq_outcome = (ie && in_service_level_flag) ? `OUT_IRQ : `OUT_NEXT;
      end
   endfunction

   // Next state logic; reset beats every other wake source
   always @* begin
      next_state = state;
      next_outcome = outcome;
      case (state)
         ST_RUN: begin
            if (internal_rst)
               next_state = ST_RESET;
            else if (ctrl[`CB_STOP])
               next_state = ST_STOP;
         end
         ST_STOP: begin
            if (internal_rst) begin
               next_state = ST_RESET;
            end else if (irq_evt && !ctrl[`CB_MASK]) begin
               next_state = ST_WAKE;
               next_outcome = irq_outcome(ctrl[`CB_LEVEL],
                  ctrl[`CB_IE], ctrl[`CB_ISP]);
            end else if (tst_evt && !ctrl[`CB_TMASK]) begin
               next_state = ST_WAKE;
               next_outcome = `OUT_NEXT;
            end
         end
         ST_WAKE: begin
            if (internal_rst)
               next_state = ST_RESET;
            else if (wait_done)
               next_state = ST_RUN;
         end
         ST_RESET: begin
            // Watchdog pulse ends on its own; pin waits for high
            if (!internal_rst)
               next_state = ST_RWAIT;
         end
         ST_RWAIT: begin
            if (internal_rst)
               next_state = ST_RESET;
            else if (wait_done)
               next_state = ST_RUN;
         end
         default: next_state = ST_RESET;
      endcase
   end

   // State, release pulses and core reset line
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_RESET;
         outcome <= `OUT_NONE;
         core_reset <= 1'b1;
         fetch_vector <= 1'b0;
         vector_fetch_addr <= `VEC_LO;
         release_next <= 1'b0;
         release_irq <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         outcome <= next_outcome;
         release_next <= 1'b0;
         release_irq <= 1'b0;
         fetch_vector <= 1'b0;
         core_reset <= (next_state == ST_RESET ||
            next_state == ST_RWAIT);
         if (state == ST_RWAIT && next_state == ST_RUN) begin
            fetch_vector <= 1'b1;
            vector_fetch_addr <= `VEC_LO;
         end
         if (state == ST_WAKE && next_state == ST_RUN) begin
            release_next <= (outcome == `OUT_NEXT);
            release_irq <= (outcome == `OUT_IRQ);
         end
      end
   end

   // High impedance during reset and its wait only, not STOP wake
   assign pins_hiz = (state == ST_RESET) || (state == ST_RWAIT);
   // Main oscillator off in STOP and while reset is held
   assign main_osc_run = !(state == ST_RESET || state == ST_STOP);
   assign stop_mode = (state == ST_STOP);

   // APB: zero wait states, no error response
   wire wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Register file; hardware reset loads defaults, memory untouched
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 8'h00;
         processor_status_word <= `RV_PSW;
         cpu_clock_control <= `RV_PCC;
         oscillator_mode_select <= `RV_OSCILLATOR_MODE_SELECT;
         oscillation_wait_select <= `RV_OSCILLATION_WAIT_SELECT;
         mm <= `RV_MM;
         expansion_ram_size <= `RV_IXS;
         internal_memory_size <= MEM_SIZE_RESET;
         t16_count <= `RV_ZERO;
         t16_clk <= `RV_ZERO;
         t16_mode <= `RV_ZERO;
         t16_out <= `RV_ZERO;
         t16_cc <= `RV_TIMER16_CAPCMP_CONTROL;
         t8a_count <= `RV_ZERO;
         t8b_count <= `RV_ZERO;
         t8_clk <= `RV_ZERO;
         t8_mode <= `RV_ZERO;
         t8_out <= `RV_ZERO;
         port_dir <= {9{`RV_DIR}};
         port_latch <= {7{`RV_ZERO}};
         pullup_high <= `RV_ZERO;
         pullup_low <= `RV_ZERO;
         vector_word <= 16'h0000;
      end else if (ce) begin
         if (state == ST_RESET) begin
            // STOP bit kept while reset is held, cleared as it lets go
            ctrl <= (next_state == ST_RESET) ? (ctrl & 8'h01) : `RV_ZERO;
            processor_status_word <= `RV_PSW;
            cpu_clock_control <= `RV_PCC;
            oscillator_mode_select <= `RV_OSCILLATOR_MODE_SELECT;
            oscillation_wait_select <= `RV_OSCILLATION_WAIT_SELECT;
            mm <= `RV_MM;
            expansion_ram_size <= `RV_IXS;
            internal_memory_size <= MEM_SIZE_RESET;
            t16_count <= `RV_ZERO;
            t16_clk <= `RV_ZERO;
            t16_mode <= `RV_ZERO;
            t16_out <= `RV_ZERO;
            t16_cc <= `RV_TIMER16_CAPCMP_CONTROL;
            t8a_count <= `RV_ZERO;
            t8b_count <= `RV_ZERO;
            t8_clk <= `RV_ZERO;
            t8_mode <= `RV_ZERO;
            t8_out <= `RV_ZERO;
            port_dir <= {9{`RV_DIR}};
            port_latch <= {7{`RV_ZERO}};
            pullup_high <= `RV_ZERO;
            pullup_low <= `RV_ZERO;
            // Memory, compares and vector word left alone
         end else if (state == ST_STOP && next_state == ST_WAKE) begin
            ctrl[`CB_STOP] <= 1'b0; // STOP consumed on release
         end else if (wr) begin
            case (paddr)
               `OFS_CTRL: ctrl <= pwdata[7:0];
               `OFS_PSW: processor_status_word <= pwdata[7:0];
               `OFS_CLK: begin
                  cpu_clock_control <= pwdata[7:0];
                  oscillator_mode_select <= pwdata[15:8];
                  oscillation_wait_select <= pwdata[23:16];
               end
               `OFS_MEM: begin
                  mm <= pwdata[7:0];
                  expansion_ram_size <= pwdata[15:8];
                  internal_memory_size <= pwdata[23:16];
               end
               `OFS_T16: begin
                  t16_count <= pwdata[7:0];
                  t16_clk <= pwdata[15:8];
                  t16_mode <= pwdata[23:16];
                  t16_out <= pwdata[31:24];
               end
               `OFS_T16CC: begin
                  t16_capcmp_a <= pwdata[15:0];
                  t16_capcmp_b <= pwdata[31:16];
               end
               `OFS_T8: begin
                  t8a_count <= pwdata[7:0];
                  t8b_count <= pwdata[15:8];
                  t8a_cmp <= pwdata[23:16];
                  t8b_cmp <= pwdata[31:24];
               end
               `OFS_PORTDIR: port_dir[7:0] <= pwdata[7:0];
               `OFS_PORTLAT: port_latch[7:0] <= pwdata[7:0];
               `OFS_PULLUP: begin
                  pullup_high <= pwdata[7:0];
                  pullup_low <= pwdata[15:8];
                  t8_clk <= pwdata[23:16];
                  t8_mode <= pwdata[31:24];
               end
               `OFS_VECTOR: vector_word <= pwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      prdata = 32'h00000000;
      case (paddr)
         `OFS_CTRL: prdata = {24'h000000, ctrl};
         `OFS_STATUS: prdata = {21'h000000, outcome, pins_hiz,
            main_osc_run, state, core_reset, stop_mode};
         `OFS_PSW: prdata = {24'h000000, processor_status_word};
         `OFS_CLK: prdata = {8'h00, oscillation_wait_select, oscillator_mode_select, cpu_clock_control};
         `OFS_MEM: prdata = {8'h00, internal_memory_size, expansion_ram_size, mm};
         `OFS_T16: prdata = {t16_out, t16_mode, t16_clk, t16_count};
         `OFS_T16CC: prdata = {t16_capcmp_b, t16_capcmp_a};
         `OFS_T8: prdata = {t8b_cmp, t8a_cmp, t8b_count, t8a_count};
         `OFS_PORTDIR: prdata = {16'h0000, t16_cc, port_dir[7:0]};
         `OFS_PORTLAT: prdata = {16'h0000, t8_out, port_latch[7:0]};
         `OFS_PULLUP: prdata = {t8_mode, t8_clk, pullup_low, pullup_high};
         `OFS_VECTOR: prdata = {16'h0000, vector_word};
         default: prdata = 32'h00000000;
      endcase
   end
endmodule

/* bench/rst_seq_props.sv */
`timescale 1ns/1ps
// Reset, wait and wake timing seen at the sequencer pins
module rst_seq_props #(
   parameter WAIT_LOG2 = 17
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Sources
   input wire ext_reset_n,
   input wire watchdog_overflow,
   input wire irq_request,
   input wire test_request,
   // Outputs under watch
   input wire core_reset,
   input wire [15:0] vector_fetch_addr,
   input wire fetch_vector,
   input wire release_next,
   input wire release_irq,
   input wire pins_hiz,
   input wire main_osc_run
);
   localparam int WAIT = 1 << WAIT_LOG2;
   int rst_cnt; // Reset cycles since the last source let go
   int wake_cnt; // Cycles a wake request has stood
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // A live source restarts the count, so a short re-reset is caught
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rst_cnt <= 0;
      else if (!ext_reset_n || watchdog_overflow)
         rst_cnt <= 0;
      else if (core_reset)
         rst_cnt <= rst_cnt + 1;
   end
   // Requests are levels, so count how long one stands
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wake_cnt <= 0;
      else if (!irq_request && !test_request)
         wake_cnt <= 0;
      else
         wake_cnt <= wake_cnt + 1;
   end
   sequence s_pin_low;
      !ext_reset_n [*4];
   endsequence
   sequence s_held;
      core_reset && pins_hiz;
   endsequence
   reset_entry_a:
      assert property ($fell(ext_reset_n) |-> ##[0:3] s_held)
      else $error("pin reset not taken");
   osc_stop_a:
      assert property (s_pin_low |-> !main_osc_run && pins_hiz)
      else $error("oscillator or pins active in reset");
   wdog_entry_a:
      assert property ($rose(watchdog_overflow) |-> ##[1:4] s_held)
      else $error("watchdog reset not taken");
   wait_min_a:
      assert property ($fell(core_reset) |-> rst_cnt >= WAIT)
      else $error("reset wait too short");
   wait_max_a:
      assert property (!(core_reset && rst_cnt > WAIT + 16))
      else $error("reset never released");
   vector_addr_a:
      assert property (fetch_vector |-> vector_fetch_addr == 16'h0000)
      else $error("wrong vector address");
   vector_pulse_a:
      assert property ($fell(core_reset) |-> ##[0:1]
         ($past(fetch_vector) || fetch_vector))
      else $error("no vector fetch at release");
   wake_min_a:
      assert property ((release_next || release_irq) |-> wake_cnt >= WAIT)
      else $error("wake before stabilization");
   one_outcome_a:
      assert property (!(release_next && release_irq))
      else $error("two wake outcomes at once");
endmodule
bind reset_sequencer rst_seq_props #(.WAIT_LOG2(WAIT_LOG2)) u_rst_seq_props (
   .pclk, .presetn, .ext_reset_n, .watchdog_overflow, .irq_request,
   .test_request, .core_reset, .vector_fetch_addr, .fetch_vector,
   .release_next, .release_irq, .pins_hiz, .main_osc_run);

/* bench/reset_src_model.sv */
`timescale 1ns/1ps
// Reset pin, watchdog and wake sources outside the sequencer
module reset_src_model (
   // Clock
   input wire pclk,
   // Driven sources
   output logic ext_reset_n,
   output logic watchdog_overflow,
   output logic irq_request,
   output logic test_request
);
   // Quiet sources from time zero
   initial begin
      ext_reset_n = 1'b1;
      watchdog_overflow = 1'b0;
      irq_request = 1'b0;
      test_request = 1'b0;
   end
   // Pin low for n cycles; 500 cycles is the 10 us minimum
   task pin_reset(input int n);
      @(posedge pclk);
      ext_reset_n <= 1'b0;
      repeat (n) @(posedge pclk);
      ext_reset_n <= 1'b1;
   endtask
   // Overflow is a one-cycle pulse
   task wd_pulse;
      @(posedge pclk);
      watchdog_overflow <= 1'b1;
      @(posedge pclk);
      watchdog_overflow <= 1'b0;
   endtask
   // Wake requests are levels held until changed
   task set_req(input logic irq, input logic tst);
      @(posedge pclk);
      irq_request <= irq;
      test_request <= tst;
   endtask
endmodule

/* bench/reset_sequencer_tb.sv */
`timescale 1ns/1ps
`include "rst_seq_defines.vh"
module reset_sequencer_tb;
   localparam int WL = 4;
   localparam int WAIT = 1 << WL;
   // Reset-value table: offset, mask, value
   localparam logic [11:0] RA [8] = '{`OFS_PSW, `OFS_CLK, `OFS_MEM,
      `OFS_T16, `OFS_T8, `OFS_PORTDIR, `OFS_PORTLAT, `OFS_PULLUP};
   localparam logic [31:0] RM [8] = '{32'hff, 32'hffffff, 32'hffffff,
      32'hffffffff, 32'hffff, 32'hffff, 32'hffff, 32'hffffffff};
   localparam logic [31:0] RV [8] = '{32'h02, 32'h040004, 32'hcf0a10,
      32'h0, 32'h0, 32'h04ff, 32'h0, 32'h0};
   // Wake table: level ie isp mask tmask irq test, then outcome
   localparam logic [8:0] WK [9] = '{{7'h06, `OUT_NEXT},
      {7'h26, `OUT_IRQ}, {7'h56, `OUT_NEXT}, {7'h46, `OUT_NEXT},
      {7'h66, `OUT_NEXT}, {7'h76, `OUT_IRQ}, {7'h7e, `OUT_NONE},
      {7'h29, `OUT_NEXT}, {7'h2d, `OUT_NONE}};
   logic pclk, presetn, psel, penable, pwrite, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire [15:0] vector_fetch_addr;
   wire pready, pslverr, core_reset, fetch_vector, release_next;
   wire release_irq, pins_hiz, main_osc_run, stop_mode;
   wire ext_reset_n, watchdog_overflow, irq_request, test_request;
   int bad_count, comparisons, i;
   reset_sequencer #(.WAIT_LOG2(WL)) u_reset_sequencer (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ce, .ext_reset_n, .watchdog_overflow,
      .irq_request, .test_request, .core_reset, .vector_fetch_addr,
      .fetch_vector, .release_next, .release_irq, .pins_hiz,
      .main_osc_run, .stop_mode);
   reset_src_model u_reset_src_model (.pclk, .ext_reset_n,
      .watchdog_overflow, .irq_request, .test_request);
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Setup, then access held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask
   // Bounded wait for the core to leave reset
   task wait_run;
      int n;
      for (n = 0; n < WAIT + 60 && core_reset !== 1'b0; n++) @(negedge pclk);
      check({31'h0, core_reset}, 32'h0);
   endtask
   task defaults;
      int k;
      for (k = 0; k < 8; k++) rchk(RA[k], RM[k], RV[k]);
   endtask
   // Enter STOP with given flags, raise a source, see which pulse ends it
   task wake(input logic [8:0] w);
      logic [1:0] got;
      int n;
      apb(1'b1, `OFS_CTRL, {26'h0, w[4], w[8], w[5], w[6], w[7], 1'b1});
      u_reset_src_model.set_req(w[3], w[2]);
      got = 2'h0;
      for (n = 0; n < 3 * WAIT + 20 && got == 2'h0; n++) begin
         @(negedge pclk);
         got = {release_irq, release_next};
      end
      u_reset_src_model.set_req(1'b0, 1'b0);
      repeat (4) @(negedge pclk);
      check({30'h0, got}, {30'h0, w[1:0]});
      check({31'h0, stop_mode}, {31'h0, w[1:0] == `OUT_NONE});
   endtask
   task wrap_up;
      $display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // The tests need about 1600 cycles; a hang stops well after that
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      wrap_up;
   end
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check({30'h0, core_reset, pins_hiz}, 32'h3);
      wait_run;
      defaults;
      rchk(12'h030, 32'hffffffff, 32'h0);
      $display("test defaults done");
      // Dirty the status word so the reset load shows
      apb(1'b1, `OFS_PSW, 32'h55);
      rchk(`OFS_PSW, 32'hff, 32'h55);
      u_reset_src_model.pin_reset(500);
      rchk(`OFS_PSW, 32'hff, 32'h02);
      wait_run;
      $display("test pin reset done");
      // Dirty the checked registers except t16_cc and t8_out so the watchdog reload shows
      for (i = 0; i < 8; i++) apb(1'b1, RA[i], 32'h5a5a5a5a);
      u_reset_src_model.wd_pulse;
      repeat (6) @(negedge pclk);
      check({31'h0, core_reset}, 32'h1);
      wait_run;
      defaults;
      $display("test watchdog done");
      for (i = 0; i < 9; i++) wake(WK[i]);
      $display("test wake done");
      // Last wake case leaves STOP in force; a pin reset ends it
      fork
         u_reset_src_model.pin_reset(500);
         begin
            repeat (20) @(posedge pclk);
            rchk(`OFS_CTRL, 32'h1, 32'h1);
            rchk(`OFS_STATUS, 32'h182, 32'h102);
         end
      join
      wait_run;
      check({31'h0, stop_mode}, 32'h0);
      rchk(`OFS_CTRL, 32'h1, 32'h0);
      $display("test stop reset done");
      wrap_up;
   end
endmodule
